// ---- logic/pcpc_defines.svh ----
`ifndef PCPC_DEFINES_SVH
`define PCPC_DEFINES_SVH

// register indices (byte address = index * 4)
`define PCPC_IDX_PLL_CTRL 10'h010
`define PCPC_IDX_PFD_CFG 10'h017
`define PCPC_IDX_CAL_CTRL 10'h018
`define PCPC_IDX_DIST_SEL 10'h1E1
`define PCPC_IDX_UPDATE 10'h232
`define PCPC_IDX_STATUS 10'h300

// field positions
`define PCPC_PWR_LSB 0
`define PCPC_PWR_MSB 1
`define PCPC_CP_LSB 4
`define PCPC_CP_MSB 6
`define PCPC_POL_BIT 7
`define PCPC_ABL_LSB 0
`define PCPC_ABL_MSB 1
`define PCPC_CPI_LSB 4
`define PCPC_CPI_MSB 6
`define PCPC_BYP_BIT 0
`define PCPC_SRC_BIT 1
`define PCPC_CAL_BIT 0

// reset values and codes
`define PCPC_RST_PLL_CTRL 8'h01
`define PCPC_RST_PFD_CFG 8'h00
`define PCPC_RST_CAL_CTRL 8'h00
`define PCPC_RST_DIST_SEL 8'h00
`define PCPC_UPDATE_CODE 8'h01
`define PCPC_PWR_NORMAL 2'h0
`define PCPC_PWR_ASYNC_DOWN 2'h1

`endif

// ---- logic/pcpc_pkg.sv ----
`default_nettype none

package pcpc_pkg;
	// charge pump mode encodings
	typedef enum logic [2:0] {
		PCPC_CP_HIGHZ = 3'b000,
		PCPC_CP_UP = 3'b001,
		PCPC_CP_DOWN = 3'b010,
		PCPC_CP_NORMAL = 3'b011
	} pcpc_cp_mode_t;

	// loop state
	typedef enum logic [1:0] {
		PCPC_ST_OFF = 2'b00,
		PCPC_ST_RUN = 2'b01,
		PCPC_ST_SYNC_DOWN = 2'b10
	} pcpc_state_t;
endpackage

`default_nettype wire

// ---- logic/pcpc_top.sv ----
// What this block does
// - power field 01b holds PLL powered down
// - power field 00b runs loop with settings
// - bypass bit routes clock around VCO divider
// - source bit 0 selects external CLK input
// - bit 7 sets detector polarity sense
// - polarity ignored when internal VCO used
// - writing 0x01 to update applies all
// - detector compares R and N edges
// - two-bit field picks antibacklash width
// - pump mode: highz, normal, up, down
// - pump current in eight equal steps
`timescale 1ns/1ns
`default_nettype none
`include "pcpc_defines.svh"

module pcpc_top #(
	parameter int ADDR_W = 12
) (
	input wire logic clk_sys, // 50 MHz system clock
	input wire logic srst, // synchronous reset, active high
	input wire logic [ADDR_W-1:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // byte lanes
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall
	input wire logic ref_div_edge, // divided reference edge pulse
	input wire logic fb_div_edge, // divided feedback edge pulse
	output logic pll_powered_down, // loop off
	output logic pll_run, // loop on, settings applied
	output logic vco_div_bypass, // distribution bypasses VCO divider
	output logic src_is_vco, // 1 internal VCO, 0 external CLK
	output logic pfd_pol_negative, // effective detector polarity
	output logic [1:0] abl_width_sel, // antibacklash width select
	output logic [2:0] cp_current_step, // pump current step 0..7
	output logic cp_pump_up, // pump up command
	output logic cp_pump_down, // pump down command
	output logic cp_high_z, // pump output tristated
	output logic vco_cal_start // one-cycle pulse to start calibration
);
	import pcpc_pkg::*;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	// low address bits must be zero, so part-word addresses miss every register
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
		hit = (a[ADDR_W-1:2] == idx[ADDR_W-3:0]) && (a[1:0] == 2'b00);
	endfunction

	logic ack_reg;
	logic [7:0] stg_pll_reg, stg_pfd_reg, stg_cal_reg, stg_dist_reg;
	logic [7:0] act_pll_reg, act_pfd_reg, act_cal_reg, act_dist_reg;
	logic [31:0] rdata_reg;
	logic up_det_reg, dn_det_reg;
	pcpc_state_t state_reg, state_next;
	logic [7:0] wbyte;
	logic req, wr_take, rd_take, do_update;
	logic hit_pll, hit_pfd, hit_cal, hit_dist, hit_upd, hit_stat;
	logic [7:0] rd_mux;

	assign req = avs_read | avs_write;
	// one wait cycle then ack; keeps read data registered
	assign avs_waitrequest = req & ~ack_reg;
	assign wr_take = avs_write & ack_reg;
	assign rd_take = avs_read & ~ack_reg;
	// registers are one byte wide; the upper lanes carry nothing
	assign wbyte = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;
	assign hit_pll = hit(avs_address, `PCPC_IDX_PLL_CTRL);
	assign hit_pfd = hit(avs_address, `PCPC_IDX_PFD_CFG);
	assign hit_cal = hit(avs_address, `PCPC_IDX_CAL_CTRL);
	assign hit_dist = hit(avs_address, `PCPC_IDX_DIST_SEL);
	assign hit_upd = hit(avs_address, `PCPC_IDX_UPDATE);
	assign hit_stat = hit(avs_address, `PCPC_IDX_STATUS);
	// only the exact code applies staged values
	assign do_update = wr_take & hit_upd & avs_byteenable[0] &
		(avs_writedata[7:0] == `PCPC_UPDATE_CODE);

	// read mux; unmapped reads as zero, update is not stored so reads zero
	assign rd_mux = hit_pll ? stg_pll_reg :
		hit_pfd ? stg_pfd_reg :
		hit_cal ? stg_cal_reg :
		hit_dist ? stg_dist_reg :
		hit_stat ? {4'h0, src_is_vco, vco_div_bypass, state_reg} : 8'h00;

	// ----------------------------------------
	// bus handshake
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= req & ~ack_reg;
			if (rd_take) begin
				rdata_reg <= {24'h00_0000, rd_mux};
			end
		end
	end
	// loaded in the wait cycle, so read data stands at the answering edge
	assign avs_readdata = rdata_reg;

	// ----------------------------------------
	// staging registers
	// ----------------------------------------
	// writes land here only; the loop keeps running on the active copy
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			stg_pll_reg <= `PCPC_RST_PLL_CTRL;
			stg_pfd_reg <= `PCPC_RST_PFD_CFG;
			stg_cal_reg <= `PCPC_RST_CAL_CTRL;
			stg_dist_reg <= `PCPC_RST_DIST_SEL;
		end else if (wr_take && avs_byteenable[0]) begin
			if (hit_pll) begin
				stg_pll_reg <= wbyte;
			end
			if (hit_pfd) begin
				stg_pfd_reg <= wbyte;
			end
			if (hit_cal) begin
				stg_cal_reg <= wbyte;
			end
			if (hit_dist) begin
				stg_dist_reg <= wbyte;
			end
		end
	end

	// ----------------------------------------
	// active registers
	// ----------------------------------------
	// all four copied on the same edge so no half-applied setup exists
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			act_pll_reg <= `PCPC_RST_PLL_CTRL;
			act_pfd_reg <= `PCPC_RST_PFD_CFG;
			act_cal_reg <= `PCPC_RST_CAL_CTRL;
			act_dist_reg <= `PCPC_RST_DIST_SEL;
		end else if (do_update) begin
			act_pll_reg <= stg_pll_reg;
			act_pfd_reg <= stg_pfd_reg;
			act_cal_reg <= stg_cal_reg;
			act_dist_reg <= stg_dist_reg;
		end
	end

	// calibration starts on a 0->1 of the active bit; relies on software
	// clearing and updating first when recalibrating
	logic cal_prev_reg;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cal_prev_reg <= 1'b0;
			vco_cal_start <= 1'b0;
		end else begin
			cal_prev_reg <= act_cal_reg[`PCPC_CAL_BIT];
			vco_cal_start <= act_cal_reg[`PCPC_CAL_BIT] & ~cal_prev_reg;
		end
	end

	// ----------------------------------------
	// loop power state
	// ----------------------------------------
	logic [1:0] pwr_field;
	assign pwr_field = act_pll_reg[`PCPC_PWR_MSB:`PCPC_PWR_LSB];

	// 10b/11b treated as a synchronous power-down state
	always_comb begin
		state_next = PCPC_ST_SYNC_DOWN;
		case (pwr_field)
			`PCPC_PWR_NORMAL: state_next = PCPC_ST_RUN;
			`PCPC_PWR_ASYNC_DOWN: state_next = PCPC_ST_OFF;
			default: state_next = PCPC_ST_SYNC_DOWN;
		endcase
	end

	// registered so the power outputs never glitch while the field is copied
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_reg <= PCPC_ST_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	// the reserved power codes count as off, the safer reading
	assign pll_powered_down = (state_reg != PCPC_ST_RUN);
	assign pll_run = (state_reg == PCPC_ST_RUN);

	// ----------------------------------------
	// routing and loop settings
	// ----------------------------------------
	// no frequency check here: a fast source with bypass set is left to software
	assign vco_div_bypass = act_dist_reg[`PCPC_BYP_BIT];
	assign src_is_vco = act_dist_reg[`PCPC_SRC_BIT];
	// internal VCO polarity is fixed, so the bit is masked there
	assign pfd_pol_negative = act_pll_reg[`PCPC_POL_BIT] & ~src_is_vco;
	assign abl_width_sel = act_pfd_reg[`PCPC_ABL_MSB:`PCPC_ABL_LSB];
	// step k gives (k+1) x 600 uA nominal, 4.8 mA at 7
	assign cp_current_step = act_pfd_reg[`PCPC_CPI_MSB:`PCPC_CPI_LSB];

	// ----------------------------------------
	// phase-frequency detector
	// ----------------------------------------
	// classic two-flop detector; both set clears both (antibacklash reset)
	logic pfd_clr;
	assign pfd_clr = (up_det_reg | ref_div_edge) & (dn_det_reg | fb_div_edge);
	// held clear while the loop is off, so a restart begins without a stale command
	always_ff @(posedge clk_sys) begin
		if (srst || !pll_run) begin
			up_det_reg <= 1'b0;
			dn_det_reg <= 1'b0;
		end else if (pfd_clr) begin
			up_det_reg <= 1'b0;
			dn_det_reg <= 1'b0;
		end else begin
			up_det_reg <= up_det_reg | ref_div_edge;
			dn_det_reg <= dn_det_reg | fb_div_edge;
		end
	end

	pcpc_cp_mode_t cp_mode;
	logic det_up, det_dn;
	assign cp_mode = pcpc_cp_mode_t'(act_pll_reg[`PCPC_CP_MSB:`PCPC_CP_LSB]);
	// polarity swaps the commands for negative-slope oscillators
	assign det_up = pfd_pol_negative ? dn_det_reg : up_det_reg;
	assign det_dn = pfd_pol_negative ? up_det_reg : dn_det_reg;

	// ----------------------------------------
	// charge pump mode
	// ----------------------------------------
	// reserved mode codes fall to high impedance, which leaves the filter node alone
	always_comb begin
		cp_pump_up = 1'b0;
		cp_pump_down = 1'b0;
		cp_high_z = 1'b1;
		if (pll_run) begin
			case (cp_mode)
				PCPC_CP_NORMAL: begin
					cp_high_z = 1'b0;
					cp_pump_up = det_up;
					cp_pump_down = det_dn;
				end
				PCPC_CP_UP: begin
					cp_high_z = 1'b0;
					cp_pump_up = 1'b1;
				end
				PCPC_CP_DOWN: begin
					cp_high_z = 1'b0;
					cp_pump_down = 1'b1;
				end
				default: cp_high_z = 1'b1;
			endcase
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// staging and update: actives move only on the update strobe
	a_stage_holds: assert property (@(posedge clk_sys) disable iff (srst)
		!do_update |=> $stable(act_pll_reg) && $stable(act_dist_reg))
		else $error("active settings changed without update");
	a_update_applies: assert property (@(posedge clk_sys) disable iff (srst)
		do_update |=> act_pll_reg == $past(stg_pll_reg) && act_pfd_reg == $past(stg_pfd_reg))
		else $error("update did not copy staged values");
	a_update_cal: assert property (@(posedge clk_sys) disable iff (srst)
		do_update |=> act_cal_reg == $past(stg_cal_reg) && act_dist_reg == $past(stg_dist_reg))
		else $error("update did not copy calibration or routing");
	a_bad_code: assert property (@(posedge clk_sys) disable iff (srst)
		wr_take && hit_upd && !do_update |=> $stable(act_pfd_reg) && $stable(act_cal_reg))
		else $error("wrong update code applied settings");
	a_write_stage: assert property (@(posedge clk_sys) disable iff (srst)
		wr_take && avs_byteenable[0] && hit_pll |=> stg_pll_reg == $past(avs_writedata[7:0]))
		else $error("write did not reach staging");

	// power state and pump silence while the loop is off
	a_power_down: assert property (@(posedge clk_sys) disable iff (srst)
		pwr_field == `PCPC_PWR_ASYNC_DOWN |=> pll_powered_down && cp_high_z)
		else $error("loop not off in power-down");
	a_power_run: assert property (@(posedge clk_sys) disable iff (srst)
		pwr_field == `PCPC_PWR_NORMAL |=> pll_run)
		else $error("loop not running in normal mode");
	a_off_quiet: assert property (@(posedge clk_sys) disable iff (srst)
		pll_powered_down |-> cp_high_z && !cp_pump_up && !cp_pump_down)
		else $error("pump active while loop is off");

	// routing and loop settings follow the staged copy on update; polarity is masked with the internal VCO
	a_bypass_route: assert property (@(posedge clk_sys) disable iff (srst)
		do_update |=> vco_div_bypass == $past(stg_dist_reg[`PCPC_BYP_BIT]) &&
			src_is_vco == $past(stg_dist_reg[`PCPC_SRC_BIT]))
		else $error("routing mismatch");
	a_pulse_update: assert property (@(posedge clk_sys) disable iff (srst)
		do_update |=> abl_width_sel == $past(stg_pfd_reg[`PCPC_ABL_MSB:`PCPC_ABL_LSB]))
		else $error("antibacklash select not applied");
	a_step_update: assert property (@(posedge clk_sys) disable iff (srst)
		do_update |=> cp_current_step == $past(stg_pfd_reg[`PCPC_CPI_MSB:`PCPC_CPI_LSB]))
		else $error("pump current step not applied");
	a_pol_ignored: assert property (@(posedge clk_sys) disable iff (srst)
		src_is_vco |-> !pfd_pol_negative)
		else $error("polarity used with internal oscillator");

	// detector and pump commands
	a_forced_up: assert property (@(posedge clk_sys) disable iff (srst)
		pll_run && cp_mode == PCPC_CP_UP |-> cp_pump_up && !cp_pump_down && !cp_high_z)
		else $error("forced pump up wrong");
	a_forced_down: assert property (@(posedge clk_sys) disable iff (srst)
		pll_run && cp_mode == PCPC_CP_DOWN |-> cp_pump_down && !cp_pump_up && !cp_high_z)
		else $error("forced pump down wrong");
	a_highz_quiet: assert property (@(posedge clk_sys) disable iff (srst)
		pll_run && cp_mode == PCPC_CP_HIGHZ |-> cp_high_z && !cp_pump_up && !cp_pump_down)
		else $error("pump not tristated in hold mode");
	a_pol_swap: assert property (@(posedge clk_sys) disable iff (srst)
		pll_run && cp_mode == PCPC_CP_NORMAL && pfd_pol_negative |->
			cp_pump_up == dn_det_reg && cp_pump_down == up_det_reg)
		else $error("negative polarity did not swap pump commands");
	a_pol_plain: assert property (@(posedge clk_sys) disable iff (srst)
		pll_run && cp_mode == PCPC_CP_NORMAL && !pfd_pol_negative |->
			cp_pump_up == up_det_reg && cp_pump_down == dn_det_reg)
		else $error("pump commands do not follow the detector");
	a_pfd_reset: assert property (@(posedge clk_sys) disable iff (srst)
		up_det_reg && dn_det_reg |-> 1'b0)
		else $error("detector flops both set");
	a_pfd_idle: assert property (@(posedge clk_sys) disable iff (srst)
		!pll_run |=> !up_det_reg && !dn_det_reg)
		else $error("detector active while loop is off");

	// calibration start and bus timing
	a_cal_pulse: assert property (@(posedge clk_sys) disable iff (srst)
		vco_cal_start |=> !vco_cal_start)
		else $error("calibration start longer than one cycle");
	a_cal_rise: assert property (@(posedge clk_sys) disable iff (srst)
		$rose(act_cal_reg[`PCPC_CAL_BIT]) |=> vco_cal_start)
		else $error("calibration start missing after bit rose");
	a_bus_ack: assert property (@(posedge clk_sys) disable iff (srst)
		$rose(req) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus answer not after one wait cycle");

endmodule // pcpc_top

`default_nettype wire

// ---- verification/pll_clock_path_config_test.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "pcpc_defines.svh"

module pll_clock_path_config_test;
	import pcpc_pkg::*;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic [11:0] avs_address = 12'h000;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic ref_div_edge = 1'b0;
	logic fb_div_edge = 1'b0;
	logic pll_powered_down, pll_run, vco_div_bypass, src_is_vco, pfd_pol_negative;
	logic [1:0] abl_width_sel;
	logic [2:0] cp_current_step;
	logic cp_pump_up, cp_pump_down, cp_high_z, vco_cal_start;
	logic [31:0] q;
	logic [7:0] r;
	logic [2:0] e;
	pcpc_cp_mode_t modes [4] = '{PCPC_CP_HIGHZ, PCPC_CP_UP, PCPC_CP_DOWN, PCPC_CP_NORMAL};
	int n_errors = 0;
	int checked = 0;
	int k;

	// -------------------------------------------------
	// clock and design
	// -------------------------------------------------
	always #10 clk_sys = ~clk_sys;

	pcpc_top #(.ADDR_W(12)) u_dut (.clk_sys(clk_sys), .srst(srst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .ref_div_edge(ref_div_edge),
		.fb_div_edge(fb_div_edge), .pll_powered_down(pll_powered_down), .pll_run(pll_run),
		.vco_div_bypass(vco_div_bypass), .src_is_vco(src_is_vco),
		.pfd_pol_negative(pfd_pol_negative), .abl_width_sel(abl_width_sel),
		.cp_current_step(cp_current_step), .cp_pump_up(cp_pump_up),
		.cp_pump_down(cp_pump_down), .cp_high_z(cp_high_z), .vco_cal_start(vco_cal_start));

	// -------------------------------------------------
	// tasks
	// -------------------------------------------------
	task automatic results();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	// expected {high_z, up, down} for a pump mode while the detector is idle
	function automatic logic [2:0] exp_pump(input logic [2:0] m);
		case (m)
			PCPC_CP_UP: exp_pump = 3'b010;
			PCPC_CP_DOWN: exp_pump = 3'b001;
			PCPC_CP_NORMAL: exp_pump = 3'b000;
			default: exp_pump = 3'b100;
		endcase
	endfunction

	// one avalon access; request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] d);
		int i;
		@(posedge clk_sys);
		avs_address <= {idx, 2'b00};
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= {24'h000000, d};
		for (i = 0; i < 20; i++) begin
			@(posedge clk_sys);
			if (avs_waitrequest === 1'b0) break;
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (i == 20) begin
			n_errors++;
			results();
		end
	endtask

	// apply staged values, then let the power state register follow
	task automatic upd();
		bus(1'b1, `PCPC_IDX_UPDATE, `PCPC_UPDATE_CODE);
		repeat (2) @(negedge clk_sys);
	endtask

	// one-cycle edge pulse on a detector input
	task automatic pulse(input logic is_ref);
		@(posedge clk_sys);
		if (is_ref) ref_div_edge <= 1'b1;
		else fb_div_edge <= 1'b1;
		@(posedge clk_sys);
		ref_div_edge <= 1'b0;
		fb_div_edge <= 1'b0;
		@(negedge clk_sys);
	endtask

	// -------------------------------------------------
	// main sequence
	// -------------------------------------------------
	initial begin
		void'($urandom(29));
		repeat (3) @(posedge clk_sys);
		srst <= 1'b0;
		@(negedge clk_sys);
		chk("powered_down", 1, pll_powered_down);
		chk("high_z", 1, cp_high_z);
		bus(1'b0, `PCPC_IDX_PLL_CTRL, 8'h00);
		chk("pll_ctrl", 32'h01, q);
		// staged writes must not move the actives; a wrong update code is ignored
		r = 8'($urandom()) & 8'h73;
		bus(1'b1, `PCPC_IDX_PLL_CTRL, 8'h30);
		bus(1'b1, `PCPC_IDX_DIST_SEL, 8'h01);
		bus(1'b1, `PCPC_IDX_PFD_CFG, r);
		bus(1'b1, `PCPC_IDX_UPDATE, 8'h02);
		repeat (2) @(negedge clk_sys);
		chk("run_staged", 0, pll_run);
		chk("bypass_staged", 0, vco_div_bypass);
		upd();
		chk("run", 1, pll_run);
		chk("bypass", 1, vco_div_bypass);
		chk("src", 0, src_is_vco);
		chk("abl", r[1:0], abl_width_sel);
		chk("step", r[6:4], cp_current_step);
		bus(1'b0, `PCPC_IDX_PFD_CFG, 8'h00);
		chk("pfd_cfg", {24'h0, r}, q);
		// detector in normal mode: reference edge first asks for up, feedback edge settles it
		pulse(1'b1);
		chk("det_up", 1, cp_pump_up);
		chk("det_dn", 0, cp_pump_down);
		pulse(1'b0);
		chk("det_clear", 0, cp_pump_up);
		// every pump mode with a random pulse width and current step
		for (k = 0; k < 4; k++) begin
			r = 8'($urandom()) & 8'h73;
			bus(1'b1, `PCPC_IDX_PFD_CFG, r);
			bus(1'b1, `PCPC_IDX_PLL_CTRL, {1'b0, modes[k], 4'h0});
			upd();
			e = exp_pump(modes[k]);
			chk("mode_hz", e[2], cp_high_z);
			chk("mode_up", e[1], cp_pump_up);
			chk("mode_dn", e[0], cp_pump_down);
			chk("abl_r", r[1:0], abl_width_sel);
			chk("step_r", r[6:4], cp_current_step);
		end
		// a reserved pump code must leave the pump tristated
		bus(1'b1, `PCPC_IDX_PLL_CTRL, 8'h70);
		upd();
		e = exp_pump(3'b111);
		chk("mode_rsv", e[2], cp_high_z);
		// polarity counts only with the external input; negative swaps the commands
		bus(1'b1, `PCPC_IDX_PLL_CTRL, 8'hB0);
		upd();
		chk("pol_ext", 1, pfd_pol_negative);
		pulse(1'b1);
		chk("pol_swap_dn", 1, cp_pump_down);
		chk("pol_swap_up", 0, cp_pump_up);
		pulse(1'b0);
		chk("pol_clear", 0, cp_pump_down);
		bus(1'b1, `PCPC_IDX_DIST_SEL, 8'h02);
		upd();
		chk("pol_vco", 0, pfd_pol_negative);
		chk("src_vco", 1, src_is_vco);
		bus(1'b1, `PCPC_IDX_PLL_CTRL, 8'h31);
		upd();
		chk("power_off", 1, pll_powered_down);
		bus(1'b0, `PCPC_IDX_STATUS, 8'h00);
		chk("status_off", 32'h08, q);
		// reserved power code: loop stays off
		bus(1'b1, `PCPC_IDX_PLL_CTRL, 8'h32);
		upd();
		chk("sync_off", 1, pll_powered_down);
		chk("sync_run", 0, pll_run);
		bus(1'b0, `PCPC_IDX_STATUS, 8'h00);
		chk("status_sync", 32'h0A, q);
		// a write with lane 0 off changes nothing and an unmapped read returns zero
		@(posedge clk_sys);
		avs_byteenable <= 4'h0;
		bus(1'b1, `PCPC_IDX_DIST_SEL, 8'h01);
		avs_byteenable <= 4'hF;
		upd();
		chk("be_off", 0, vco_div_bypass);
		bus(1'b0, 10'h3FF, 8'h00);
		chk("unmapped", 0, q);
		// recalibration: clear, update, set, update; start pulse must follow
		bus(1'b1, `PCPC_IDX_CAL_CTRL, 8'h00);
		upd();
		pulse(1'b1); // a reference edge present before calibration is set
		bus(1'b1, `PCPC_IDX_CAL_CTRL, 8'h01);
		bus(1'b1, `PCPC_IDX_UPDATE, `PCPC_UPDATE_CODE);
		for (k = 0; k < 8 && vco_cal_start !== 1'b1; k++) @(negedge clk_sys);
		chk("cal_start", 1, vco_cal_start);
		@(negedge clk_sys);
		chk("cal_pulse", 0, vco_cal_start);
		results();
	end
endmodule // pll_clock_path_config_test

`default_nettype wire
